// File: hw/ssfd_decoder.sv
// Servo wedge decoder: sync, mark, index, track, bursts, position
`timescale 1ns/1ps
module ssfd_decoder
  import ssfd_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SERVO_TICK,
  input wire logic SERVO_PULSE,
  input wire ssfd_burst_type BURST_IN,
  input wire logic [7:0] ACT_CURRENT,
  input wire logic [TRK_W-1:0] TARGET_TRACK,
  output logic GATE_A,
  output logic GATE_B,
  output logic GATE_C,
  output logic INDEX_PULSE,
  output logic WEDGE_DONE,
  output logic MISS_ERR,
  output logic [6:0] WEDGE_NUM,
  output logic [TRK_W-1:0] TRACK,
  output logic [POS_W-1:0] POS,
  output logic [VEL_W-1:0] VEL,
  output ssfd_mode_type MODE
);
  ssfd_state_type st_q;
  ssfd_burst_type smp_q;
  logic [7:0] gap_q;
  logic [7:0] cnt_q;
  logic [3:0] run_q;
  logic [3:0] cell_q;
  logic marks_q;
  logic bit_q;
  logic idx_q;
  logic [TRK_W-1:0] gray_q;

  wire tick = SERVO_TICK;
  wire pulse = SERVO_TICK & SERVO_PULSE;
  wire [7:0] gap_now = gap_q + 8'h01;
  wire is_pre = pulse && gap_now == PRE_GAP;
  wire is_mark = pulse && gap_now == MARK_GAP;
  wire cell_end = cnt_q == CELL_T - 8'h01;
  wire cell_bit = bit_q | SERVO_PULSE;
  wire mark_late = cnt_q == MARK_WIN - 8'h01;
  wire area_end = cnt_q == AREA_T - 8'h01;
  wire in_burst = st_q == ST_BURST;
  wire gate_a_w = in_burst && cnt_q >= A_START && cnt_q < B_START;
  wire gate_b_w = in_burst && cnt_q >= B_START && cnt_q < C_START;
  wire gate_c_w = in_burst && cnt_q >= C_START && cnt_q < C_END;

  logic [TRK_W-1:0] bin_w;
  genvar gi;
  generate
    for (gi = 0; gi < TRK_W; gi++) begin : g_gray
      assign bin_w[gi] = ^gray_q[TRK_W-1:gi];
    end
  endgenerate

  // coarse: B near even track centre, A near odd
  wire [7:0] frac_w = bin_w[0] ? smp_q.a : smp_q.b;
  wire [POS_W-1:0] pos_coarse = {bin_w, frac_w, 1'b0};
  // fine: A equals C on track, difference is offset
  wire [8:0] ac_diff = {1'b0, smp_q.a} - {1'b0, smp_q.c};
  wire [POS_W-1:0] pos_fine = {bin_w, 9'h000} +
                              {{(POS_W-9){ac_diff[8]}}, ac_diff};
  wire fine_md = MODE == MD_FINE || MODE == MD_FOLLOW;
  wire [POS_W-1:0] pos_w = fine_md ? pos_fine : pos_coarse;
  wire [12:0] trk_delta = {1'b0, bin_w} - {1'b0, TRACK};
  wire [15:0] delta_ext = {{3{trk_delta[12]}}, trk_delta};
  wire [15:0] cur_ext = {{8{ACT_CURRENT[7]}}, ACT_CURRENT};
  wire [VEL_W-1:0] vel_w = 16'(delta_ext * VEL_TRK_GAIN + cur_ext);
  // Mode choice from distance to target and fine offset
  wire [12:0] tgt_diff = {1'b0, TARGET_TRACK} - {1'b0, bin_w};
  wire [12:0] dist_w = tgt_diff[12] ? 13'(-tgt_diff) : tgt_diff;
  wire [8:0] off_abs = ac_diff[8] ? 9'(-ac_diff) : ac_diff;
  ssfd_mode_type mode_w;
  assign mode_w = dist_w >= SEEK_VEL_MIN ? MD_VEL :
                  dist_w != 13'h0000 ? MD_COARSE :
                  off_abs > ONTRK_TOL ? MD_FINE : MD_FOLLOW;
  wire done_w = tick && in_burst && area_end;
  // wedge count restarts at the index wedge
  wire [6:0] wedge_w = idx_q ? 7'h00 :
                       WEDGE_NUM == WEDGES - 7'h01 ? 7'h00 :
                       WEDGE_NUM + 7'h01;

  // Pulse spacing tracker
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) gap_q <= 8'h00;
    else if (pulse) gap_q <= 8'h00;
    else if (tick && gap_q != 8'hFF) gap_q <= gap_now;
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st_q <= ST_HUNT;
      cnt_q <= 8'h00;
      run_q <= 4'h0;
      marks_q <= 1'b0;
      cell_q <= 4'h0;
      bit_q <= 1'b0;
      idx_q <= 1'b0;
      gray_q <= '0;
      smp_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 8'h01;
      case (st_q)
        ST_HUNT: begin
          if (pulse) run_q <= is_pre ? run_q + 4'h1 : 4'h0;
          if (is_pre && run_q == SYNC_RUN - 4'h1) begin
            st_q <= ST_SYNC;
            cnt_q <= 8'h00;
            marks_q <= 1'b0;
          end
        end
        // two 14-period gaps in a row
        ST_SYNC: begin
          if (is_mark && marks_q) begin
            st_q <= ST_DATA;
            cnt_q <= 8'h00;
            cell_q <= CELL_ZERO;
            bit_q <= 1'b0;
            idx_q <= 1'b0;
          end else if (mark_late) begin
            st_q <= ST_HUNT;
            run_q <= 4'h0;
          end else if (pulse) begin
            marks_q <= is_mark;
          end
        end
        ST_DATA: begin
          bit_q <= cell_bit;
          if (cell_end) begin
            cnt_q <= 8'h00;
            bit_q <= 1'b0;
            cell_q <= cell_q + 4'h1;
            if (cell_q == CELL_ZERO && cell_bit) begin
              st_q <= ST_HUNT;
              run_q <= 4'h0;
            end
            if (cell_q == CELL_INDEX) idx_q <= cell_bit;
            if (cell_q > CELL_INDEX) gray_q <= {gray_q[TRK_W-2:0], cell_bit};
            if (cell_q == CELL_LAST) st_q <= ST_BURST;
          end
        end
        ST_BURST: begin
          // take the digitised amplitude at each burst end
          if (cnt_q == B_START - 8'h01) smp_q.a <= BURST_IN.a;
          if (cnt_q == C_START - 8'h01) smp_q.b <= BURST_IN.b;
          if (cnt_q == C_END - 8'h01) smp_q.c <= BURST_IN.c;
          if (area_end) begin
            st_q <= ST_HUNT;
            run_q <= 4'h0;
          end
        end
        default: st_q <= ST_HUNT;
      endcase
    end
  end

  // missed mark: late window or nonzero mark bit
  wire miss_sync = st_q == ST_SYNC && mark_late && !(is_mark && marks_q);
  wire miss_zero = st_q == ST_DATA && cell_end &&
                   cell_q == CELL_ZERO && cell_bit;
  wire miss_w = tick && (miss_sync || miss_zero);
  // index pulse when index bit is one
  wire index_w = tick && st_q == ST_DATA && cell_end &&
                 cell_q == CELL_INDEX && cell_bit;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      GATE_A <= 1'b0;
      GATE_B <= 1'b0;
      GATE_C <= 1'b0;
      INDEX_PULSE <= 1'b0;
      WEDGE_DONE <= 1'b0;
      MISS_ERR <= 1'b0;
    end else begin
      GATE_A <= gate_a_w;
      GATE_B <= gate_b_w;
      GATE_C <= gate_c_w;
      INDEX_PULSE <= index_w;
      WEDGE_DONE <= done_w;
      MISS_ERR <= miss_w;
    end
  end

  // results move only on a completed wedge
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      WEDGE_NUM <= 7'h00;
      TRACK <= '0;
      POS <= '0;
      VEL <= '0;
      MODE <= MD_VEL;
    end else if (done_w) begin
      WEDGE_NUM <= wedge_w;
      TRACK <= bin_w;
      POS <= pos_w;
      VEL <= vel_w;
      MODE <= mode_w;
    end
  end

  // Helper: ticks seen while any gate is high
  logic [7:0] gticks_q;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) gticks_q <= 8'h00;
    else if (!in_burst) gticks_q <= 8'h00;
    else if (tick && (gate_a_w | gate_b_w | gate_c_w))
      gticks_q <= gticks_q + 8'h01;
  end

  sequence s_a_end;
    $fell(GATE_A) ##0 !RST;
  endsequence
  sequence s_mark_found;
    st_q == ST_SYNC ##1 st_q == ST_DATA;
  endsequence

  chk_sync_lock: assert property (@(posedge MCLK) disable iff (RST)
    st_q == ST_HUNT ##1 st_q == ST_SYNC |-> $past(run_q) == SYNC_RUN - 4'h1)
    else $error("sync lock without full preamble run");
  chk_mark_pair: assert property (@(posedge MCLK) disable iff (RST)
    s_mark_found |-> $past(marks_q) && $past(gap_now) == MARK_GAP)
    else $error("data entered without two mark gaps");
  chk_index_once: assert property (@(posedge MCLK) disable iff (RST)
    INDEX_PULSE |=> !INDEX_PULSE ##1 idx_q)
    else $error("index pulse not single or not latched");
  chk_gray_conv: assert property (@(posedge MCLK) disable iff (RST)
    WEDGE_DONE |-> (TRACK ^ (TRACK >> 1)) == gray_q)
    else $error("track is not the binary of the Gray field");
  chk_gate_order: assert property (@(posedge MCLK) disable iff (RST)
    s_a_end |-> GATE_B && !GATE_C)
    else $error("B gate does not follow A gate");
  chk_burst_span: assert property (@(posedge MCLK) disable iff (RST)
    $fell(GATE_C) |-> gticks_q == 3 * BURST_T)
    else $error("burst gates did not span three bursts");
  chk_gate_excl: assert property (@(posedge MCLK) disable iff (RST)
    $onehot0({GATE_A, GATE_B, GATE_C}))
    else $error("more than one burst gate high");
  chk_wedge_range: assert property (@(posedge MCLK) disable iff (RST)
    WEDGE_NUM < WEDGES)
    else $error("wedge number beyond one revolution");
  chk_vel_mode: assert property (@(posedge MCLK) disable iff (RST)
    WEDGE_DONE |-> (MODE == MD_VEL) == ($past(dist_w) >= SEEK_VEL_MIN))
    else $error("velocity mode not tied to long seek");
  chk_miss_hold: assert property (@(posedge MCLK) disable iff (RST)
    MISS_ERR |-> $stable(POS) && $stable(TRACK) ##1 st_q == ST_HUNT)
    else $error("position changed on a missed wedge");
endmodule : ssfd_decoder

// File: hw/ssfd_pkg.sv
// Constants and types for the sector servo field decoder
package ssfd_pkg;
  localparam int TRK_W = 12;
  localparam int POS_W = 21;
  localparam int VEL_W = 16;
  // Preamble made of 3-period patterns
  localparam int GAIN_T = 88;
  localparam int SYNC_T = 40;
  localparam logic [7:0] PRE_GAP = 8'h03;
  localparam logic [3:0] SYNC_RUN = 4'hA;
  // Address mark and servo data cells
  localparam logic [7:0] MARK_GAP = 8'h0E;
  localparam logic [7:0] CELL_T = 8'h09;
  localparam logic [3:0] CELL_ZERO = 4'h0;
  localparam logic [3:0] CELL_INDEX = 4'h1;
  localparam logic [3:0] CELL_LAST = 4'hD;
  localparam logic [7:0] MARK_WIN = 8'(GAIN_T + SYNC_T + 2 * MARK_GAP);
  // Burst area layout in servo periods, then wedge count, mode thresholds and velocity gain
  localparam logic [7:0] ERASE_T = 8'h09;
  localparam logic [7:0] BURST_T = 8'h2A;
  localparam logic [7:0] A_START = ERASE_T;
  localparam logic [7:0] B_START = A_START + BURST_T;
  localparam logic [7:0] C_START = B_START + BURST_T;
  localparam logic [7:0] C_END = C_START + BURST_T;
  localparam logic [7:0] AREA_T = 8'h90;
  localparam logic [6:0] WEDGES = 7'h4E;
  localparam logic [12:0] SEEK_VEL_MIN = 13'h0014;
  localparam logic [8:0] ONTRK_TOL = 9'h010;
  localparam logic [15:0] VEL_TRK_GAIN = 16'h0008;

  typedef enum logic [1:0] {
    MD_VEL, MD_COARSE, MD_FINE, MD_FOLLOW
  } ssfd_mode_type;

  typedef enum logic [2:0] {
    ST_HUNT, ST_SYNC, ST_DATA, ST_BURST
  } ssfd_state_type;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } ssfd_burst_type;
endpackage : ssfd_pkg

// File: verification/ssfd_chan_model.sv
// Read channel model: servo tick and raw pulse stream of one wedge
`timescale 1ns/1ps
module ssfd_chan_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic idx,
  input wire logic miss,
  input wire logic [11:0] gray,
  output logic tick,
  output logic pulse,
  output logic busy
);
  int t;

  // wedge pulse pattern; miss alone drops the mark
  // miss with idx puts a one into the mark's zero cell
  // data cells are sent only after the mark
  function automatic logic pat(int k);
    int c;
    c = (k - 155) / 9;
    if (k <= 126) return k % 3 == 0;
    if (miss && !idx) return 1'b0;
    if (k == 140 || k == 154) return 1'b1;
    if (k < 155 || k >= 281 || (k - 155) % 9 != 4) return 1'b0;
    if (c == 0) return miss;
    if (c == 1) return idx;
    return gray[13-c];
  endfunction : pat

  // one servo period every two clocks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick <= 1'b0;
      pulse <= 1'b0;
      busy <= 1'b0;
      t <= 0;
    end else begin
      tick <= ~tick;
      pulse <= ~tick & busy & pat(t);
      if (go && !busy) begin
        busy <= 1'b1;
        t <= 0;
      end else if (busy && !tick) begin
        t <= t + 1;
        if (t == 440) busy <= 1'b0;
      end
    end
  end
endmodule : ssfd_chan_model

// File: verification/testbench.sv
// Self-checking bench for the servo wedge decoder
`timescale 1ns/1ps
module testbench;
  import ssfd_pkg::*;
  localparam logic [11:0] BIN = 12'h5A4;
  logic MCLK = 0, RST = 1, go = 0, idx = 0, miss = 0, tick, pulse, busy;
  logic [11:0] gray = 0, tgt = 0;
  logic [7:0] act = 8'hFE;
  ssfd_burst_type bst = '0;
  logic ga, gb, gc, ip, wd, me;
  logic [6:0] wn;
  logic [11:0] trk;
  logic [20:0] pos;
  logic [15:0] vel;
  ssfd_mode_type md, pm;
  int error_cnt = 0, samples_checked = 0;
  int n_idx, n_done, n_miss, n_a, n_b, n_c, n_ovl;

  always #12.5 MCLK = ~MCLK;

  ssfd_chan_model chan (.clk(MCLK), .rst(RST), .go(go), .idx(idx),
    .miss(miss), .gray(gray), .tick(tick), .pulse(pulse), .busy(busy));

  ssfd_decoder dut (.MCLK(MCLK), .RST(RST), .SERVO_TICK(tick),
    .SERVO_PULSE(pulse), .BURST_IN(bst), .ACT_CURRENT(act),
    .TARGET_TRACK(tgt), .GATE_A(ga), .GATE_B(gb), .GATE_C(gc),
    .INDEX_PULSE(ip), .WEDGE_DONE(wd), .MISS_ERR(me), .WEDGE_NUM(wn),
    .TRACK(trk), .POS(pos), .VEL(vel), .MODE(md));

  // Counters cleared while go is high, at the start of each wedge
  always @(posedge MCLK) begin
    if (go) begin
      {n_idx, n_done, n_miss, n_a, n_b, n_c, n_ovl} = '0;
    end else begin
      n_idx += int'(ip === 1'b1);
      n_done += int'(wd === 1'b1);
      n_miss += int'(me === 1'b1);
      n_a += int'(ga === 1'b1);
      n_b += int'(gb === 1'b1);
      n_c += int'(gc === 1'b1);
      n_ovl += int'(((ga & gb) | (gb & gc) | (ga & gc)) !== 1'b0);
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task report_and_stop;
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task run_wedge(input logic i, input logic m, input logic [11:0] b);
    int k;
    @(posedge MCLK);
    idx <= i;
    miss <= m;
    gray <= b ^ (b >> 1);
    go <= 1'b1;
    @(posedge MCLK);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge MCLK);
      k++;
    end while (busy === 1'b1 && k < 2000);
    if (k >= 2000) begin
      error_cnt++;
      report_and_stop();
    end
    repeat (4) @(posedge MCLK);
    chk(n_a, m ? 0 : 84);
    chk(n_b, m ? 0 : 84);
    chk(n_c, m ? 0 : 84);
    chk(n_ovl, 0);
    chk(n_idx, i && !m);
    chk(n_done, !m);
    chk(n_miss, m);
  endtask : run_wedge

  task t_far_index;
    bst <= '{a: 8'h20, b: 8'h60, c: 8'h30};
    tgt <= BIN + 12'd100;
    run_wedge(1'b1, 1'b0, BIN);
    chk(wn, 0);
    chk(trk, BIN);
    chk(pos, {BIN, 8'h60, 1'b0});
    chk(vel, 16'(16'({4'h0, BIN} * 8) + 16'hFFFE));
    chk(md, MD_VEL);
  endtask : t_far_index

  task t_on_track;
    bst <= '{a: 8'h80, b: 8'hFF, c: 8'h70};
    tgt <= BIN;
    repeat (3) begin
      pm = md;
      run_wedge(1'b0, 1'b0, BIN);
      chk(md == MD_VEL, 0);
    end
    chk(wn, 3);
    chk(md, MD_FOLLOW);
    chk(pos, pm >= MD_FINE ? {BIN, 9'h010} : {BIN, 8'hFF, 1'b0});
    chk(vel, 16'hFFFE);
  endtask : t_on_track

  task t_step;
    tgt <= BIN + 12'd21;
    run_wedge(1'b0, 1'b0, BIN + 12'd1);
    chk(trk, BIN + 12'd1);
    chk(md, MD_VEL);
    chk(vel, 16'd6);
    chk(pos, {BIN + 12'd1, 9'h010});
    chk(wn, 4);
  endtask : t_step

  task t_missed_mark;
    logic [20:0] p;
    logic [11:0] tr;
    p = pos;
    tr = trk;
    run_wedge(1'b0, 1'b1, BIN);
    chk(pos, p);
    chk(trk, tr);
    run_wedge(1'b1, 1'b1, BIN);
    chk(pos, p);
    chk(trk, tr);
  endtask : t_missed_mark

  task t_settle;
    act <= 8'h05;
    bst <= '{a: 8'h40, b: 8'h00, c: 8'h10};
    tgt <= BIN + 12'd13;
    run_wedge(1'b0, 1'b0, BIN + 12'd3);
    chk(md, MD_COARSE);
    chk(pos, {BIN + 12'd3, 8'h40, 1'b0});
    chk(vel, 16'h0015);
    tgt <= BIN + 12'd3;
    run_wedge(1'b0, 1'b0, BIN + 12'd3);
    chk(md, MD_FINE);
    chk(pos, {BIN + 12'd3, 8'h40, 1'b0});
    chk(vel, 16'h0005);
    bst <= '{a: 8'h10, b: 8'h00, c: 8'h40};
    run_wedge(1'b0, 1'b0, BIN + 12'd3);
    chk(md, MD_FINE);
    chk(pos, {BIN + 12'd2, 9'h1D0});
    chk(wn, 7);
  endtask : t_settle

  initial begin
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    repeat (3) @(posedge MCLK);
    t_far_index();
    t_on_track();
    t_step();
    t_missed_mark();
    t_settle();
    report_and_stop();
  end
endmodule : testbench
